// ==== tec_pkg.sv ====
// Shared constants and types for the thermometer/memory command engine
package tec_pkg;

    // Clock rate and documented times
    localparam int CLK_PERIOD_NS = 50;
    localparam int PROG_TIME_NS = 50_000_000;
    localparam int CFG_TIME_NS = 10_000_000;
    // Longest times round down to whole cycles
    localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int CFG_CYCLES_DEF = CFG_TIME_NS / CLK_PERIOD_NS;
    localparam int TIMER_W = 20;
    typedef logic [TIMER_W-1:0] tec_timer_t;
    localparam tec_timer_t TIMER_ZERO = 20'h00000;
    localparam tec_timer_t TIMER_STEP = 20'h00001;

    // Command codes
    localparam logic [7:0] CMD_READ_TEMP = 8'haa;
    localparam logic [7:0] CMD_CONV_START = 8'hee;
    localparam logic [7:0] CMD_CONV_STOP = 8'h22;
    localparam logic [7:0] CMD_MEMORY = 8'h17;
    localparam logic [7:0] CMD_CONFIG = 8'hac;
    localparam logic [7:0] CMD_NONE = 8'h00;

    // Control byte layout; device code value is arbitrary
    localparam int CODE_W = 4;
    localparam int SEL_W = 3;
    localparam int CTRL_CODE_LSB = 4;
    localparam int CTRL_SEL_LSB = 1;
    localparam int CTRL_DIR_BIT = 0;
    localparam logic [CODE_W-1:0] DEV_CODE = 4'h5;

    // Configuration register layout and reset value
    localparam int CFG_SINGLE_BIT = 0;
    localparam logic [5:0] CFG_FIXED = 6'h05;
    localparam logic CFG_SINGLE_RST = 1'b0;

    // Temperature register
    localparam int TEMP_W = 16;
    localparam int TEMP_FRAC_W = 4;
    localparam logic [TEMP_FRAC_W-1:0] TEMP_LOW_ZERO = 4'h0;
    localparam logic [TEMP_W-1:0] TEMP_RST = 16'h0000;
    localparam logic [1:0] TEMP_IDX_MSB = 2'h0;
    localparam logic [1:0] TEMP_IDX_LSB = 2'h1;
    localparam logic [1:0] TEMP_IDX_END = 2'h2;
    localparam logic [1:0] TEMP_STEP = 2'h1;

    // Memory array and page buffer
    localparam int MEM_DEPTH = 256;
    localparam int ADDR_W = 8;
    localparam int PAGE_SIZE = 8;
    localparam int PAGE_W = 3;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_TOP = 8'hff;
    localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
    localparam logic [PAGE_W-1:0] PAGE_STEP = 3'h1;
    localparam logic [PAGE_W-1:0] PAGE_LAST = 3'h7;
    localparam logic [PAGE_W-1:0] PAGE_FIRST = 3'h0;
    localparam logic [7:0] FILL_BYTE = 8'hff;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Link events delivered by the bit-level front end
    typedef enum logic [1:0] {
        EV_START = 2'h0,
        EV_STOP = 2'h1,
        EV_RX = 2'h2,
        EV_TX = 2'h3
    } tec_kind_t;

    // Transfer phases, one-hot
    typedef enum logic [6:0] {
        ST_ADDR = 7'h01,
        ST_CMD = 7'h02,
        ST_MADDR = 7'h04,
        ST_MWR = 7'h08,
        ST_CFGW = 7'h10,
        ST_READ = 7'h20,
        ST_IDLE = 7'h40
    } tec_state_t;

endpackage

// ==== tec_mem.sv ====
// Byte memory with one write port and a registered read port
`timescale 1ns/10ps
module tec_mem (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Write port
    input wire logic i_we,
    input wire logic [tec_pkg::ADDR_W-1:0] i_waddr,
    input wire logic [7:0] i_wdata,
    // Read port
    input wire logic [tec_pkg::ADDR_W-1:0] i_raddr,
    output logic [7:0] o_rdata
);
    import tec_pkg::*;

    logic [7:0] mem_q [MEM_DEPTH];

    // Array has no reset; contents stand in for nonvolatile cells
    always_ff @(posedge i_clock) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
    end

    // Read data always comes from a register
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= BYTE_ZERO;
        end else begin
            o_rdata <= mem_q[i_raddr];
        end
    end

endmodule

// ==== tec_engine.sv ====
// Command engine: link handshake, command decode, memory and conversions
//
// Behaviour
// - Byte after memory command loads address pointer.
// - Memory write acks and buffers bytes in page.
// - STOP after memory write starts programming.
// - Repeated START instead of STOP discards buffer.
// - No acknowledge while programming, done within 50ms.
// - Page writes step only the low pointer bits.
// - One data byte then STOP programs one byte.
// - Reads send byte, step pointer while acked.
// - Read pointer wraps from top to zero.
// - Read ends on master not-ack and STOP.
// - Command byte acknowledged before any data.
// - Read-temperature returns two bytes, MSB first.
// - Start-convert runs once or continuously.
// - Stop-convert finishes current conversion, then idles.
// - Config command writes or returns configuration.
// - Control byte acked only on code and select.
// - Single-select bit picks one-shot or continuous.
// - Done bit reads one when conversion complete.
// - Temperature is 16-bit, low nibble zero.
`timescale 1ns/10ps
module tec_engine #(
    parameter int PROG_CYCLES = tec_pkg::PROG_CYCLES_DEF,
    parameter int CFG_CYCLES = tec_pkg::CFG_CYCLES_DEF
) (
    // Clocks and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_link_clock,
    // Link events from the bit-level front end (link clock)
    input wire logic i_link_event,
    input wire tec_pkg::tec_kind_t i_link_kind,
    input wire logic [7:0] i_link_data,
    // Link answers (link clock)
    output logic o_link_ready,
    output logic o_link_answer,
    output logic o_link_ack,
    output logic [7:0] o_link_tx_byte,
    // Device select strap pins
    input wire logic [tec_pkg::SEL_W-1:0] i_select,
    // Converter
    input wire logic i_conv_done,
    input wire logic [tec_pkg::TEMP_W-1:0] i_conv_result,
    output logic o_conv_start
);
    import tec_pkg::*;

    // ---------------- Link domain ----------------
    logic l_wait_q;
    logic l_req_tog_q;
    tec_kind_t l_kind_q;
    logic [7:0] l_data_q;
    logic l_ans_s1_q;
    logic l_ans_s2_q;
    logic c_ans_tog_q;
    logic c_ack_q;
    logic [7:0] c_tx_q;

    // One event is in flight at a time; events while waiting are dropped
    wire l_take = i_link_event && !l_wait_q;
    wire l_done = l_wait_q && (l_ans_s2_q == l_req_tog_q);
    wire l_wait_d = l_take || (l_wait_q && !l_done);

    // Capture the event and toggle the request; fields hold until answered
    always_ff @(posedge i_link_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            l_req_tog_q <= 1'b0;
            l_kind_q <= EV_START;
            l_data_q <= BYTE_ZERO;
        end else if (l_take) begin
            l_req_tog_q <= ~l_req_tog_q;
            l_kind_q <= i_link_kind;
            l_data_q <= i_link_data;
        end
    end

    // Answer toggle synchroniser and answer presentation
    always_ff @(posedge i_link_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            l_ans_s1_q <= 1'b0;
            l_ans_s2_q <= 1'b0;
            l_wait_q <= 1'b0;
            o_link_ready <= 1'b1;
            o_link_answer <= 1'b0;
            o_link_ack <= 1'b0;
            o_link_tx_byte <= FILL_BYTE;
        end else begin
            l_ans_s1_q <= c_ans_tog_q;
            l_ans_s2_q <= l_ans_s1_q;
            l_wait_q <= l_wait_d;
            o_link_ready <= !l_wait_d;
            o_link_answer <= l_done;
            // Core holds ack and byte stable until the next request
            if (l_done) begin
                o_link_ack <= c_ack_q;
                o_link_tx_byte <= c_tx_q;
            end
        end
    end

    // ---------------- Core domain ----------------
    logic c_req_s1_q;
    logic c_req_s2_q;
    logic c_req_s3_q;
    logic [SEL_W-1:0] c_sel_s1_q;
    logic [SEL_W-1:0] c_sel_s2_q;
    tec_state_t state_q;
    logic [7:0] cmd_q;
    logic [ADDR_W-1:0] ptr_q;
    logic [7:0] buf_q [PAGE_SIZE];
    logic [PAGE_SIZE-1:0] bvalid_q;
    logic [1:0] tx_idx_q;
    logic prog_q;
    logic [PAGE_W-1:0] prog_idx_q;
    tec_timer_t timer_q;
    logic cfg_single_q;
    logic conv_busy_q;
    logic conv_run_q;
    logic [TEMP_W-1:0] temp_q;
    logic [7:0] mem_rdata;

    // Request toggle and strap synchronisers
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            c_req_s1_q <= 1'b0;
            c_req_s2_q <= 1'b0;
            c_req_s3_q <= 1'b0;
            c_sel_s1_q <= '0;
            c_sel_s2_q <= '0;
        end else begin
            c_req_s1_q <= l_req_tog_q;
            c_req_s2_q <= c_req_s1_q;
            c_req_s3_q <= c_req_s2_q;
            c_sel_s1_q <= i_select;
            c_sel_s2_q <= c_sel_s1_q;
        end
    end

    // Event decode
    wire req_new = c_req_s2_q ^ c_req_s3_q;
    wire ev_start = req_new && (l_kind_q == EV_START);
    wire ev_stop = req_new && (l_kind_q == EV_STOP);
    wire rx = req_new && (l_kind_q == EV_RX);
    wire tx_req = req_new && (l_kind_q == EV_TX) && (state_q == ST_READ);
    wire busy = prog_q || (timer_q != TIMER_ZERO);
    wire [CODE_W-1:0] rx_code = l_data_q[CTRL_CODE_LSB +: CODE_W];
    wire [SEL_W-1:0] rx_sel = l_data_q[CTRL_SEL_LSB +: SEL_W];
    wire addr_match = (rx_code == DEV_CODE) && (rx_sel == c_sel_s2_q)
        && !busy;
    wire [PAGE_W-1:0] ptr_page = ptr_q[PAGE_W-1:0];
    wire [ADDR_W-1:0] ptr_step = {ptr_q[ADDR_W-1:PAGE_W],
        ptr_page + PAGE_STEP};
    wire commit = ev_stop && (state_q == ST_MWR) && (|bvalid_q);
    wire prog_last = prog_q && (prog_idx_q == PAGE_LAST);
    wire cmd_rx = rx && (state_q == ST_CMD);
    wire cfg_wr = rx && (state_q == ST_CFGW);

    // Answer selection
    wire [7:0] cfg_byte = {!conv_busy_q, CFG_FIXED, cfg_single_q};
    wire [7:0] temp_byte = (tx_idx_q == TEMP_IDX_MSB) ? temp_q[15:8] :
        (tx_idx_q == TEMP_IDX_LSB) ? temp_q[7:0] : FILL_BYTE;
    wire [7:0] tx_byte = (cmd_q == CMD_MEMORY) ? mem_rdata :
        (cmd_q == CMD_CONFIG) ? cfg_byte :
        (cmd_q == CMD_READ_TEMP) ? temp_byte : FILL_BYTE;
    wire ack_rx = (state_q == ST_ADDR) ? addr_match :
        (state_q == ST_CMD) || (state_q == ST_MADDR) ||
        (state_q == ST_MWR) || (state_q == ST_CFGW);

    // Answer each request; the toggle flips on the same edge that loads ack and byte
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            c_ans_tog_q <= 1'b0;
            c_ack_q <= 1'b0;
            c_tx_q <= FILL_BYTE;
        end else if (req_new) begin
            c_ans_tog_q <= ~c_ans_tog_q;
            c_ack_q <= rx && ack_rx;
            c_tx_q <= tx_req ? tx_byte : FILL_BYTE;
        end
    end

    // Transfer state, command, pointer and page buffer
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= ST_IDLE;
            cmd_q <= CMD_NONE;
            ptr_q <= ADDR_RST;
            bvalid_q <= '0;
            tx_idx_q <= TEMP_IDX_MSB;
            for (int i = 0; i < PAGE_SIZE; i++) begin
                buf_q[i] <= BYTE_ZERO;
            end
        end else if (ev_start) begin
            // A start before the stop abandons buffered bytes
            state_q <= ST_ADDR;
            if (!prog_q) begin
                bvalid_q <= '0;
            end
        end else if (ev_stop) begin
            state_q <= ST_IDLE;
        end else if (rx) begin
            case (state_q)
                ST_ADDR: begin
                    tx_idx_q <= TEMP_IDX_MSB;
                    if (!addr_match) begin
                        state_q <= ST_IDLE;
                    end else if (l_data_q[CTRL_DIR_BIT]) begin
                        state_q <= ST_READ;
                    end else begin
                        state_q <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    cmd_q <= l_data_q;
                    if (l_data_q == CMD_MEMORY) begin
                        state_q <= ST_MADDR;
                    end else if (l_data_q == CMD_CONFIG) begin
                        state_q <= ST_CFGW;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_MADDR: begin
                    ptr_q <= l_data_q;
                    bvalid_q <= '0;
                    state_q <= ST_MWR;
                end
                ST_MWR: begin
                    buf_q[ptr_page] <= l_data_q;
                    bvalid_q[ptr_page] <= 1'b1;
                    ptr_q <= ptr_step;
                end
                ST_CFGW: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end else if (tx_req) begin
            if (tx_idx_q != TEMP_IDX_END) begin
                tx_idx_q <= tx_idx_q + TEMP_STEP;
            end
            if (cmd_q == CMD_MEMORY) begin
                ptr_q <= ptr_q + ADDR_STEP;
            end
        end else if (prog_last) begin
            bvalid_q <= '0;
        end
    end

    // Programming: copy valid page bytes, then hold busy for the write time
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prog_q <= 1'b0;
            prog_idx_q <= PAGE_FIRST;
            timer_q <= TIMER_ZERO;
        end else if (commit) begin
            prog_q <= 1'b1;
            prog_idx_q <= PAGE_FIRST;
        end else if (prog_q) begin
            prog_idx_q <= prog_idx_q + PAGE_STEP;
            if (prog_last) begin
                prog_q <= 1'b0;
                timer_q <= tec_timer_t'(PROG_CYCLES);
            end
        end else if (cfg_wr) begin
            timer_q <= tec_timer_t'(CFG_CYCLES);
        end else if (timer_q != TIMER_ZERO) begin
            timer_q <= timer_q - TIMER_STEP;
        end
    end

    // Only buffered slots are written; the page base is the pointer's top
    wire mem_we = prog_q && bvalid_q[prog_idx_q];
    wire [ADDR_W-1:0] mem_waddr = {ptr_q[ADDR_W-1:PAGE_W], prog_idx_q};

    tec_mem u_mem (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_we(mem_we),
        .i_waddr(mem_waddr),
        .i_wdata(buf_q[prog_idx_q]),
        .i_raddr(ptr_q),
        .o_rdata(mem_rdata)
    );

    // Conversion control and configuration; single-select sets one-shot
    wire conv_go = cmd_rx && (l_data_q == CMD_CONV_START);
    wire conv_halt = cmd_rx && (l_data_q == CMD_CONV_STOP);
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_conv_start <= 1'b0;
            conv_busy_q <= 1'b0;
            conv_run_q <= 1'b0;
            temp_q <= TEMP_RST;
            cfg_single_q <= CFG_SINGLE_RST;
        end else begin
            o_conv_start <= 1'b0;
            if (cfg_wr) begin
                cfg_single_q <= l_data_q[CFG_SINGLE_BIT];
            end
            if (i_conv_done && conv_busy_q) begin
                temp_q <= {i_conv_result[TEMP_W-1:TEMP_FRAC_W],
                    TEMP_LOW_ZERO};
                // Continuous mode restarts unless a stop came in
                if (conv_run_q && !conv_halt) begin
                    o_conv_start <= 1'b1;
                end else begin
                    conv_busy_q <= 1'b0;
                end
            end else if (conv_go && !conv_busy_q) begin
                o_conv_start <= 1'b1;
                conv_busy_q <= 1'b1;
            end
            if (conv_go) begin
                conv_run_q <= !cfg_single_q;
            end else if (conv_halt) begin
                conv_run_q <= 1'b0;
            end
        end
    end

    // Checks on the core logic
    ack_when_busy_a: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        rx && (state_q == ST_ADDR) && busy |=> !c_ack_q)
        else $error("control byte acknowledged while programming");
    cmd_byte_ack_a: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        cmd_rx |=> c_ack_q)
        else $error("command byte not acknowledged");
    pointer_load_a: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        rx && (state_q == ST_MADDR) |=> ptr_q == $past(l_data_q))
        else $error("word address not loaded into pointer");
    page_step_a: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        rx && (state_q == ST_MWR) |=>
        (ptr_q[7:3] == $past(ptr_q[7:3])) &&
        (ptr_q[2:0] == $past(ptr_q[2:0]) + PAGE_STEP))
        else $error("page write pointer stepped wrongly");
    prog_span_a: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        commit |=> prog_q [*8] ##1 (!prog_q && busy))
        else $error("programming cycle did not run eight slots");
    abort_clear_a: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        ev_start && !prog_q |=> (bvalid_q == '0) && !prog_q)
        else $error("repeated start did not discard buffer");
    read_wrap_a: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        tx_req && (cmd_q == CMD_MEMORY) && (ptr_q == ADDR_TOP)
        |=> ptr_q == ADDR_RST)
        else $error("read pointer did not wrap to zero");
    temp_msb_a: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        tx_req && (cmd_q == CMD_READ_TEMP) && (tx_idx_q == TEMP_IDX_MSB)
        |=> c_tx_q == temp_q[15:8])
        else $error("temperature high byte not sent first");
    conv_pulse_a: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        conv_go && !conv_busy_q |=> o_conv_start && conv_busy_q
        ##1 !o_conv_start)
        else $error("start command did not pulse converter once");
    temp_nibble_a: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        temp_q[3:0] == TEMP_LOW_ZERO)
        else $error("temperature low nibble not zero");

endmodule

// ==== tec_master_model.sv ====
// Link front-end model: offers byte-level events as a bus master would
`timescale 1ns/10ps
module tec_master_model (
    // Link clock and answers from the engine
    input wire logic i_link_clock,
    input wire logic i_ready,
    input wire logic i_answer,
    input wire logic i_ack,
    input wire logic [7:0] i_tx_byte,
    // Offered events
    output logic o_event,
    output tec_pkg::tec_kind_t o_kind,
    output logic [7:0] o_data
);
    import tec_pkg::*;
    // Idle link cycles before each event; nonzero gives a slow master
    int gap = 0;

    initial begin
        o_event = 1'b0;
        o_kind = EV_STOP;
        o_data = 8'h00;
    end

    // One event: wait for ready, pulse, then wait for the answer
    task automatic xfer(input tec_kind_t kind, input logic [7:0] data,
                        output logic ack, output logic [7:0] rx);
        int n;
        n = 0;
        // Always launch on a falling link edge, even when called mid-cycle
        repeat (gap + 1) @(negedge i_link_clock);
        while (i_ready !== 1'b1 && n < 100) begin
            @(negedge i_link_clock);
            n++;
        end
        o_event = 1'b1;
        o_kind = kind;
        o_data = data;
        @(negedge i_link_clock);
        // Released data never keeps its last value
        o_event = 1'b0;
        o_data = ~data;
        while (i_answer !== 1'b1 && n < 100) begin
            @(negedge i_link_clock);
            n++;
        end
        // A lost answer poisons both results so any check fails
        ack = (n < 100) ? i_ack : 1'bx;
        rx = (n < 100) ? i_tx_byte : 8'hxx;
    endtask

    // START, then control byte with code, select and direction
    task automatic open_frame(input logic [2:0] sel, input logic rd,
                              output logic ack);
        logic [7:0] d;
        logic a;
        xfer(EV_START, 8'h00, a, d);
        xfer(EV_RX, {DEV_CODE, sel, rd}, ack, d);
    endtask
endmodule

// ==== test_thermo_eeprom_command_engine.sv ====
// Self-checking bench for the thermometer/memory command engine
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("FAIL %0t got %h want %h", $time, g, e); end end
module test_thermo_eeprom_command_engine;
    import tec_pkg::*;
    localparam logic [2:0] SEL = 3'h3;
    logic i_clock = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_link_clock;
    logic ev, ready, answer, lack, cstart, cdone;
    tec_kind_t kind;
    logic [7:0] ldata, txb;
    logic [2:0] sel = SEL;
    logic [15:0] cres = 16'h0000;
    logic ak, ok;
    logic [7:0] rb;
    int fail_count = 0;
    int n_checks = 0;
    int starts = 0;
    int s;

    // Core clock, and a link clock offset in phase
    always #25 i_clock = ~i_clock;
    initial begin
        i_link_clock = 1'b0;
        #1.7;
        forever #3 i_link_clock = ~i_link_clock;
    end
    // Count start pulses where they are settled, away from the launch edge
    always @(negedge i_clock) if (cstart === 1'b1) starts++;

    tec_engine #(.PROG_CYCLES(20), .CFG_CYCLES(10)) tec_engine_i (
        .i_clock(i_clock), .i_reset_n(i_reset_n),
        .i_link_clock(i_link_clock), .i_link_event(ev),
        .i_link_kind(kind), .i_link_data(ldata), .o_link_ready(ready),
        .o_link_answer(answer), .o_link_ack(lack), .o_link_tx_byte(txb),
        .i_select(sel), .i_conv_done(cdone), .i_conv_result(cres),
        .o_conv_start(cstart));
    tec_master_model tec_master_model_i (
        .i_link_clock(i_link_clock), .i_ready(ready), .i_answer(answer),
        .i_ack(lack), .i_tx_byte(txb), .o_event(ev), .o_kind(kind),
        .o_data(ldata));

    // Bus-cycle helpers
    task automatic ev1(input tec_kind_t k);
        tec_master_model_i.xfer(k, 8'h00, ak, rb);
    endtask
    task automatic snd(input logic [7:0] b, input logic e);
        tec_master_model_i.xfer(EV_RX, b, ak, rb);
        `CHK(ak, e)
    endtask
    task automatic get(input logic [7:0] e);
        tec_master_model_i.xfer(EV_TX, 8'h00, ak, rb);
        `CHK(rb, e)
    endtask
    task automatic opn(input logic rd, input logic e);
        tec_master_model_i.open_frame(SEL, rd, ak);
        `CHK(ak, e)
    endtask
    task automatic cmd(input logic [7:0] c);
        opn(1'b0, 1'b1);
        snd(c, 1'b1);
    endtask
    // Poll with control bytes until the device answers again
    task automatic idle();
        int n;
        n = 0;
        do begin
            tec_master_model_i.open_frame(SEL, 1'b0, ok);
            ev1(EV_STOP);
            n++;
        end while (ok !== 1'b1 && n < 60);
        `CHK(ok, 1'b1)
    endtask
    task automatic rdmem(input logic [7:0] a);
        cmd(CMD_MEMORY);
        snd(a, 1'b1);
        opn(1'b1, 1'b1);
    endtask
    task automatic cfgw(input logic [7:0] v);
        cmd(CMD_CONFIG);
        snd(v, 1'b1);
        ev1(EV_STOP);
        idle();
    endtask
    task automatic cfgr(input logic [7:0] e);
        cmd(CMD_CONFIG);
        opn(1'b1, 1'b1);
        get(e);
        ev1(EV_STOP);
    endtask
    task automatic temp(input logic [15:0] e);
        cmd(CMD_READ_TEMP);
        opn(1'b1, 1'b1);
        get(e[15:8]);
        get(e[7:0]);
        ev1(EV_STOP);
    endtask
    // Converter finishes with a result; core inputs change off the edge
    task automatic done(input logic [15:0] r);
        @(negedge i_clock);
        cdone = 1'b1;
        cres = r;
        @(negedge i_clock);
        cdone = 1'b0;
        cres = ~r;
        repeat (4) @(negedge i_clock);
    endtask
    task automatic conv();
        s = starts;
        cmd(CMD_CONV_START);
        ev1(EV_STOP);
        repeat (4) @(negedge i_clock);
        `CHK(starts, s + 1)
    endtask

    // Scenarios
    task automatic t_addr();
        ev1(EV_START);
        snd({4'ha, SEL, 1'b0}, 1'b0);
        snd(CMD_MEMORY, 1'b0);
        ev1(EV_STOP);
        tec_master_model_i.open_frame(3'h4, 1'b0, ak);
        `CHK(ak, 1'b0)
        ev1(EV_STOP);
    endtask
    task automatic t_page();
        cmd(CMD_MEMORY);
        snd(8'h00, 1'b1);
        for (int i = 0; i < 10; i++) snd(8'(17 * i), 1'b1);
        ev1(EV_STOP);
        opn(1'b0, 1'b0);
        ev1(EV_STOP);
        idle();
        rdmem(8'h00);
        for (int i = 0; i < 8; i++) get(8'(17 * (i < 2 ? i + 8 : i)));
        ev1(EV_STOP);
    endtask
    task automatic t_abort();
        cmd(CMD_MEMORY);
        snd(8'h00, 1'b1);
        snd(8'h5a, 1'b1);
        ev1(EV_START);
        snd({DEV_CODE, SEL, 1'b0}, 1'b1);
        snd(CMD_MEMORY, 1'b1);
        snd(8'h00, 1'b1);
        opn(1'b1, 1'b1);
        get(8'h88);
        ev1(EV_STOP);
    endtask
    task automatic t_single();
        tec_master_model_i.gap = 5;
        cmd(CMD_MEMORY);
        snd(8'hff, 1'b1);
        snd(8'h3c, 1'b1);
        ev1(EV_STOP);
        idle();
        rdmem(8'hff);
        get(8'h3c);
        get(8'h88);
        get(8'h99);
        ev1(EV_STOP);
        tec_master_model_i.gap = 0;
    endtask
    task automatic t_oneshot();
        cfgw(8'h01);
        conv();
        cfgr({1'b0, CFG_FIXED, 1'b1});
        done(16'h19ff);
        `CHK(starts, s + 1)
        cfgr({1'b1, CFG_FIXED, 1'b1});
        temp(16'h19f0);
    endtask
    task automatic t_cont();
        cfgw(8'h00);
        conv();
        done(16'he6f3);
        `CHK(starts, s + 2)
        cmd(CMD_CONV_STOP);
        ev1(EV_STOP);
        done(16'hc905);
        `CHK(starts, s + 2)
        temp(16'hc900);
        cfgr({1'b1, CFG_FIXED, 1'b0});
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run of some tens of microseconds
    initial begin
        #2_000_000;
        fail_count++;
        end_sim();
    end

    initial begin
        cdone = 1'b0;
        repeat (12) @(negedge i_clock);
        i_reset_n = 1'b1;
        repeat (4) @(negedge i_clock);
        t_addr();
        t_page();
        t_abort();
        t_single();
        t_oneshot();
        t_cont();
        end_sim();
    end
endmodule
